// ---- hw/pcn_pkg.sv ----
// constants, encodings and the state type for the power-config command block
// ----------------------------------------------------------------------------
// Behaviour
// - code 02 reads and writes the on/off source configuration byte
// - on/off byte: bits 4..1 writable; bits 7..5 and 0 read-only
// - code 03 clears all set fault bits and releases the alert line
// - code 10 is the lock byte: bits 7..5 writable, zero after reset
// - lock bit 5 set: only lock, operation and on/off writes pass
// - lock bit 6 set: only lock and operation writes pass
// - lock bit 7 set: only writes to the lock byte pass
// - code 11 copies all settings to memory, taking about 50 ms
// - code 12 reloads all settings from non-volatile memory
// - code 13 data byte names one register to copy into memory
// - code 01 operation byte, still writable under lock bits 5 and 6
// ----------------------------------------------------------------------------
package pcn_pkg;
   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_ON_OFF = 8'h02;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
   localparam logic [7:0] CMD_STORE_ALL = 8'h11;
   localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
   localparam logic [7:0] CMD_STORE_ONE = 8'h13;
   // ----------------------------------------------------------------
   // field layouts and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_WR_MASK = 8'hBC;
   localparam logic [7:0] ON_OFF_WR_MASK = 8'h1E;
   localparam logic [7:0] LOCK_WR_MASK = 8'hE0;
   localparam int LOCK_EXCEPT_POWER_CFG = 5;
   localparam int LOCK_OP_ONLY = 6;
   localparam int LOCK_ALL_BUT_PROTECT = 7;
   localparam logic [7:0] OP_RST = 8'h00;
   localparam logic [7:0] ON_OFF_RST = 8'h00;
   localparam logic [7:0] LOCK_RST = 8'h00;
   localparam logic [7:0] FAULT_RST = 8'h00;
   // ----------------------------------------------------------------
   // memory image slots
   // ----------------------------------------------------------------
   localparam int NV_SLOTS = 3;
   localparam int SLOT_OP = 0;
   localparam int SLOT_ON_OFF = 1;
   localparam int SLOT_LOCK = 2;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int STORE_TIME_MS = 50;
   localparam int STORE_CYCLES = (CLK_HZ / 1000) * STORE_TIME_MS;
   // store sequencer states
   typedef enum logic [1:0] {
      NV_IDLE = 2'b01,
      NV_BUSY = 2'b10
   } pcn_nv_state_t;
endpackage : pcn_pkg

// ---- hw/pcn_nvm.sv ----
// flip-flop image of the non-volatile settings with a timed store sequencer
`timescale 1ns/1ns
module pcn_nvm import pcn_pkg::*; #(
   parameter int STORE_CYC = STORE_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // store request, one bit per slot
   input wire logic store_i,
   input wire logic [NV_SLOTS-1:0] store_sel_i,
   input wire logic [7:0] live_i [NV_SLOTS],
   // image and status
   output logic [7:0] image_o [NV_SLOTS],
   output logic busy_o
);
   localparam int CW = $clog2(STORE_CYC + 1);

   // elaboration check: a zero-length store would still raise busy and wrap the count below zero
   if (STORE_CYC < 1) begin : g_bad_store_cyc
      $error("pcn_nvm: STORE_CYC must be at least 1");
   end

   pcn_nv_state_t state, next_state;
   logic [CW-1:0] cnt, next_cnt;
   logic take;

   // ----------------------------------------------------------------
   // sequencer: snapshot taken at the start, busy for the store time
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      take = 1'b0;
      case (state)
         NV_IDLE: begin
            if (store_i) begin
               take = 1'b1;
               next_cnt = CW'(STORE_CYC - 1);
               next_state = NV_BUSY;
            end
         end
         NV_BUSY: begin
            if (cnt == '0) next_state = NV_IDLE;
            else next_cnt = cnt - 1'b1;
         end
         default: next_state = NV_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= NV_IDLE;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   assign busy_o = (state == NV_BUSY);

   // one slot per entry; a request while busy is dropped by the caller
   for (genvar g = 0; g < NV_SLOTS; g++) begin : g_slot
      logic [7:0] next_img;
      always_comb begin
         next_img = image_o[g];
         if (take && store_sel_i[g]) next_img = live_i[g];
      end
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) image_o[g] <= 8'h00;
         else image_o[g] <= next_img;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_store_starts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state == NV_IDLE && store_i) |=> busy_o && cnt == CW'(STORE_CYC - 1))
      else $error("store did not start busy period");
   a_store_ends: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (busy_o && cnt == '0) |=> !busy_o)
      else $error("busy period did not end");
endmodule : pcn_nvm

// ---- hw/pcn_cfg_protect.sv ----
// command interpreter for on/off config, fault clear, write lock and settings store
`timescale 1ns/1ns
module pcn_cfg_protect import pcn_pkg::*; #(
   parameter int STORE_CYC = STORE_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // decoded bus command
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [7:0] cmd_data_i,
   // command answer
   output logic rsp_valid_o,
   output logic rsp_refused_o,
   output logic [7:0] rsp_data_o,
   output logic nvm_busy_o,
   // fault events from the power stage
   input wire logic [7:0] fault_event_i,
   // settings and status
   output logic [7:0] operation_o,
   output logic [7:0] on_off_cfg_o,
   output logic [7:0] write_lock_o,
   output logic [7:0] fault_status_o,
   // open-drain alert, oe low while pulling low
   output logic smbalert_o,
   output logic smbalert_oe_n_o
);
   logic [7:0] operation, on_off_source_config, bus_write_lock, fault_status;
   logic [7:0] next_operation, next_on_off, next_lock, next_fault;
   logic rsp_valid, rsp_refused;
   logic [7:0] rsp_data;
   logic next_rsp_valid, next_rsp_refused;
   logic [7:0] next_rsp_data;
   logic wr, permitted, nv_cmd, accept, restore_all;
   logic store_req;
   logic [NV_SLOTS-1:0] store_sel;
   logic [7:0] live [NV_SLOTS];
   logic [7:0] image [NV_SLOTS];

   // elaboration check: the busy check below needs a store of two cycles or more
   if (STORE_CYC < 2) begin : g_bad_store_cyc
      $error("pcn_cfg_protect: STORE_CYC must be at least 2");
   end

   // ----------------------------------------------------------------
   // write lock decode
   // ----------------------------------------------------------------
   // the lock bits are checked independently, so a host that breaks the
   // one-bit-only convention still gets the strictest of its settings
   always_comb begin
      wr = cmd_valid_i && cmd_write_i;
      permitted = 1'b1;
      if (bus_write_lock[LOCK_ALL_BUT_PROTECT] && cmd_code_i != CMD_WRITE_LOCK)
         permitted = 1'b0;
      if (bus_write_lock[LOCK_OP_ONLY] && cmd_code_i != CMD_WRITE_LOCK && cmd_code_i != CMD_OPERATION)
         permitted = 1'b0;
      if (bus_write_lock[LOCK_EXCEPT_POWER_CFG] && cmd_code_i != CMD_WRITE_LOCK
          && cmd_code_i != CMD_OPERATION && cmd_code_i != CMD_ON_OFF)
         permitted = 1'b0;
      nv_cmd = (cmd_code_i == CMD_STORE_ALL) || (cmd_code_i == CMD_RESTORE_ALL)
               || (cmd_code_i == CMD_STORE_ONE);
      // memory commands are refused while a store is running
      accept = wr && permitted && !(nv_cmd && nvm_busy_o);
      restore_all = accept && cmd_code_i == CMD_RESTORE_ALL;
   end

   // ----------------------------------------------------------------
   // store requests
   // ----------------------------------------------------------------
   always_comb begin
      store_req = 1'b0;
      store_sel = '0;
      if (accept && cmd_code_i == CMD_STORE_ALL) begin
         store_req = 1'b1;
         store_sel = '1;
      end else if (accept && cmd_code_i == CMD_STORE_ONE) begin
         // unknown codes in the data byte store nothing
         case (cmd_data_i)
            CMD_OPERATION: store_sel[SLOT_OP] = 1'b1;
            CMD_ON_OFF: store_sel[SLOT_ON_OFF] = 1'b1;
            CMD_WRITE_LOCK: store_sel[SLOT_LOCK] = 1'b1;
            default: store_sel = '0;
         endcase
         store_req = |store_sel;
      end
   end

   assign live[SLOT_OP] = operation;
   assign live[SLOT_ON_OFF] = on_off_source_config;
   assign live[SLOT_LOCK] = bus_write_lock;

   pcn_nvm #(.STORE_CYC(STORE_CYC)) u_nvm (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .store_i(store_req),
      .store_sel_i(store_sel),
      .live_i(live),
      .image_o(image),
      .busy_o(nvm_busy_o)
   );

   // ----------------------------------------------------------------
   // settings and fault registers
   // ----------------------------------------------------------------
   always_comb begin
      next_operation = operation;
      next_on_off = on_off_source_config;
      next_lock = bus_write_lock;
      if (restore_all) begin
         next_operation = image[SLOT_OP] & OP_WR_MASK;
         next_on_off = image[SLOT_ON_OFF] & ON_OFF_WR_MASK;
         next_lock = image[SLOT_LOCK] & LOCK_WR_MASK;
      end else if (accept) begin
         case (cmd_code_i)
            CMD_OPERATION: next_operation = cmd_data_i & OP_WR_MASK;
            CMD_ON_OFF: next_on_off = cmd_data_i & ON_OFF_WR_MASK;
            CMD_WRITE_LOCK: next_lock = cmd_data_i & LOCK_WR_MASK;
            default: next_lock = bus_write_lock;
         endcase
      end
      // a fault arriving with the clear still sets its bit
      next_fault = fault_status | fault_event_i;
      if (accept && cmd_code_i == CMD_CLEAR_FAULTS)
         next_fault = fault_event_i;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         operation <= OP_RST;
         on_off_source_config <= ON_OFF_RST;
         bus_write_lock <= LOCK_RST;
         fault_status <= FAULT_RST;
      end else begin
         operation <= next_operation;
         on_off_source_config <= next_on_off;
         bus_write_lock <= next_lock;
         fault_status <= next_fault;
      end
   end

   // ----------------------------------------------------------------
   // command answer: one cycle after each command
   // ----------------------------------------------------------------
   always_comb begin
      next_rsp_valid = cmd_valid_i;
      next_rsp_refused = wr && !accept;
      next_rsp_data = 8'h00;
      if (cmd_valid_i && !cmd_write_i) begin
         case (cmd_code_i)
            CMD_OPERATION: next_rsp_data = operation;
            CMD_ON_OFF: next_rsp_data = on_off_source_config;
            CMD_WRITE_LOCK: next_rsp_data = bus_write_lock;
            default: next_rsp_data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rsp_valid <= 1'b0;
         rsp_refused <= 1'b0;
         rsp_data <= 8'h00;
      end else begin
         rsp_valid <= next_rsp_valid;
         rsp_refused <= next_rsp_refused;
         rsp_data <= next_rsp_data;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rsp_valid_o = rsp_valid;
   assign rsp_refused_o = rsp_refused;
   assign rsp_data_o = rsp_data;
   assign operation_o = operation;
   assign on_off_cfg_o = on_off_source_config;
   assign write_lock_o = bus_write_lock;
   assign fault_status_o = fault_status;
   assign smbalert_o = 1'b0;
   assign smbalert_oe_n_o = ~|fault_status;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_clear_faults: assert property (
      (wr && permitted && cmd_code_i == CMD_CLEAR_FAULTS && fault_event_i == 8'h00)
      |=> fault_status_o == 8'h00 && smbalert_oe_n_o)
      else $error("clear did not empty faults and release alert");
   a_alert_follows: assert property (
      (fault_event_i != 8'h00) |=> !smbalert_oe_n_o)
      else $error("alert not driven after a fault");
   a_onoff_fixed: assert property (
      on_off_cfg_o[7:5] == 3'b000 && on_off_cfg_o[0] == 1'b0)
      else $error("read-only on/off bits changed");
   a_lock_low_zero: assert property (write_lock_o[4:0] == 5'h00)
      else $error("lock byte low bits not zero");
   a_lock_all_ref: assert property (
      (wr && write_lock_o[LOCK_ALL_BUT_PROTECT] && cmd_code_i != CMD_WRITE_LOCK) |=> rsp_refused_o)
      else $error("write passed full lock");
   a_lock_op_ref: assert property (
      (wr && write_lock_o[LOCK_OP_ONLY] && cmd_code_i == CMD_ON_OFF)
      |=> rsp_refused_o && $stable(on_off_cfg_o))
      else $error("on/off write passed operation-only lock");
   a_lock_cfg_ref: assert property (
      (wr && write_lock_o[LOCK_EXCEPT_POWER_CFG] && cmd_code_i == CMD_STORE_ALL && !nvm_busy_o)
      |=> rsp_refused_o && !nvm_busy_o)
      else $error("store passed power-config lock");
   a_op_write: assert property (
      (wr && !write_lock_o[LOCK_ALL_BUT_PROTECT] && cmd_code_i == CMD_OPERATION)
      |=> operation_o == ($past(cmd_data_i) & OP_WR_MASK))
      else $error("operation write not taken");
   a_store_busy: assert property (
      (accept && cmd_code_i == CMD_STORE_ALL) |=> nvm_busy_o [*2])
      else $error("store all did not start");
   a_restore_all: assert property (
      restore_all |=> on_off_cfg_o == ($past(image[SLOT_ON_OFF]) & ON_OFF_WR_MASK))
      else $error("restore did not reload on/off byte");
   a_refused_keep: assert property (
      rsp_refused_o |-> $stable(operation_o) && $stable(on_off_cfg_o) && $stable(write_lock_o))
      else $error("refused write changed a register");
endmodule : pcn_cfg_protect

// ---- testbench/pcn_host_model.sv ----
// host-side model issuing decoded bus commands to the config block
`timescale 1ns/1ns
module pcn_host_model (
   // clock
   input wire logic clk_i,
   // decoded command towards the block
   output logic cmd_valid_o,
   output logic cmd_write_o,
   output logic [7:0] cmd_code_o,
   output logic [7:0] cmd_data_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_write_o = 1'b0;
      cmd_code_o = 8'h00;
      cmd_data_o = 8'h00;
   end
   // one command per call; idle fields scrambled so nothing leans on stale values
   task automatic issue(input logic wr, input logic [7:0] code, input logic [7:0] data);
      if (wr && code == 8'h10 && !$onehot0(data[7:5])) begin
         $display("host: lock byte carries several lock bits");
      end
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_write_o <= wr;
      cmd_code_o <= code;
      cmd_data_o <= data;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_write_o <= ~wr;
      cmd_code_o <= ~code;
      cmd_data_o <= ~data;
   endtask : issue
endmodule : pcn_host_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the config, lock and store command block
`timescale 1ns/1ns
module tb_top;
   import pcn_pkg::*;
   localparam int STORE_CYC = 4;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cmd_valid_i, cmd_write_i, rsp_valid_o, rsp_refused_o, nvm_busy_o, smbalert_o, smbalert_oe_n_o;
   logic [7:0] cmd_code_i, cmd_data_i, rsp_data_o, operation_o, on_off_cfg_o, write_lock_o, fault_status_o;
   logic [7:0] fault_event_i = 8'h00;
   logic [7:0] exp_op = 8'h00;
   logic [7:0] exp_cfg = 8'h00;
   logic [7:0] locks [3] = '{8'h20, 8'h40, 8'h80};
   logic [7:0] codes [3] = '{CMD_OPERATION, CMD_ON_OFF, CMD_CLEAR_FAULTS};
   logic ok;
   int failures = 0;
   int checks_done = 0;
   int n;
   always #10 clk_i = ~clk_i;
   pcn_host_model HOST (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
      .cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i));
   pcn_cfg_protect #(.STORE_CYC(STORE_CYC)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
      .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o), .rsp_refused_o(rsp_refused_o),
      .rsp_data_o(rsp_data_o), .nvm_busy_o(nvm_busy_o), .fault_event_i(fault_event_i),
      .operation_o(operation_o), .on_off_cfg_o(on_off_cfg_o), .write_lock_o(write_lock_o),
      .fault_status_o(fault_status_o), .smbalert_o(smbalert_o), .smbalert_oe_n_o(smbalert_oe_n_o));
   // ------------------------------------------------------------
   // compare, access and closing tasks
   // ------------------------------------------------------------
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp8
   task automatic cmp1(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : cmp1
   // answer lands on the taking edge; look just after it settles
   task automatic wr(input logic [7:0] code, input logic [7:0] data, input logic refused);
      HOST.issue(1'b1, code, data);
      #1;
      cmp1(rsp_valid_o, 1'b1, "write answer");
      cmp1(rsp_refused_o, refused, "write refusal");
   endtask : wr
   task automatic rd(input logic [7:0] code, input logic [7:0] exp);
      HOST.issue(1'b0, code, 8'h00);
      #1;
      cmp1(rsp_valid_o, 1'b1, "read answer");
      cmp8(rsp_data_o, exp, "read data");
   endtask : rd
   // bounded wait for the store to end, counting busy cycles
   task automatic wait_store();
      n = 1;
      while (nvm_busy_o === 1'b1 && n < 100) begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask : wait_store
   task automatic give_verdict();
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   // watchdog: the tests need fewer than a hundred cycles
   initial begin
      #(3000 * 20);
      failures++;
      give_verdict();
   end
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(CMD_WRITE_LOCK, LOCK_RST);
      rd(CMD_ON_OFF, ON_OFF_RST);
      cmp1(smbalert_oe_n_o, 1'b1, "alert idle");
      wr(CMD_ON_OFF, 8'hFF, 1'b0);
      exp_cfg = 8'h1E;
      rd(CMD_ON_OFF, exp_cfg);
      $display("test config byte done");
      // raise two faults so a locked clear has something to leave alone
      @(posedge clk_i);
      fault_event_i <= 8'h05;
      @(posedge clk_i);
      fault_event_i <= 8'h00;
      @(posedge clk_i);
      #1;
      cmp8(fault_status_o, 8'h05, "fault latch");
      cmp1(smbalert_oe_n_o, 1'b0, "alert driven");
      for (int i = 0; i < 3; i++) begin
         wr(CMD_WRITE_LOCK, locks[i] | 8'h1F, 1'b0);
         cmp8(write_lock_o, locks[i], "lock byte");
         for (int j = 0; j < 3; j++) begin
            ok = (j == 0 && i < 2) || (j == 1 && i == 0);
            wr(codes[j], 8'h35 + 8'(i * 16 + j), !ok);
            if (ok && j == 0) exp_op = (8'h35 + 8'(i * 16 + j)) & OP_WR_MASK;
            if (ok && j == 1) exp_cfg = (8'h35 + 8'(i * 16 + j)) & ON_OFF_WR_MASK;
            cmp8(operation_o, exp_op, "operation byte");
            cmp8(on_off_cfg_o, exp_cfg, "on/off byte");
            cmp8(fault_status_o, 8'h05, "faults kept");
         end
         wr(CMD_STORE_ALL, 8'h00, 1'b1);
         cmp1(nvm_busy_o, 1'b0, "no store under lock");
         wr(CMD_WRITE_LOCK, 8'h00, 1'b0);
      end
      $display("test write lock done");
      wr(CMD_CLEAR_FAULTS, 8'h00, 1'b0);
      cmp8(fault_status_o, 8'h00, "faults cleared");
      cmp1(smbalert_oe_n_o, 1'b1, "alert released");
      cmp1(smbalert_o, 1'b0, "alert data low");
      $display("test clear faults done");
      wr(CMD_ON_OFF, 8'h0A, 1'b0);
      wr(CMD_OPERATION, 8'h80, 1'b0);
      wr(CMD_STORE_ALL, 8'h00, 1'b0);
      cmp1(nvm_busy_o, 1'b1, "store busy");
      wait_store();
      cmp8(8'(n), 8'(STORE_CYC + 1), "store length");
      wr(CMD_ON_OFF, 8'h04, 1'b0);
      wr(CMD_RESTORE_ALL, 8'h00, 1'b0);
      cmp8(on_off_cfg_o, 8'h0A, "restored on/off");
      $display("test store and restore done");
      wr(CMD_ON_OFF, 8'h1C, 1'b0);
      wr(CMD_OPERATION, 8'h84, 1'b0);
      wr(CMD_STORE_ONE, CMD_ON_OFF, 1'b0);
      wr(CMD_STORE_ONE, CMD_OPERATION, 1'b1);
      wr(CMD_RESTORE_ALL, 8'h00, 1'b1);
      cmp8(on_off_cfg_o, 8'h1C, "no restore while busy");
      wait_store();
      wr(CMD_STORE_ONE, CMD_CLEAR_FAULTS, 1'b0);
      cmp1(nvm_busy_o, 1'b0, "unknown code stores nothing");
      wr(CMD_RESTORE_ALL, 8'h00, 1'b0);
      cmp8(on_off_cfg_o, 8'h1C, "single slot stored");
      cmp8(operation_o, 8'h80, "other slot untouched");
      rd(CMD_OPERATION, 8'h80);
      $display("test store one done");
      give_verdict();
   end
endmodule : tb_top
